// ### common/dacs_pkg.sv
// Package: constants and types for the dual converter conversion sequencer
package dacs_pkg;
  // Sample width of each converter; the 14-bit variant uses the low bits with the top two bits held at zero
  localparam int RES_W = 16;
  localparam int RES_W_NARROW = 14;
  localparam logic [RES_W-1:0] NEG_FULLSCALE_16 = 16'h8000;
  localparam logic [RES_W-1:0] POS_FULLSCALE_16 = 16'h7fff;
  localparam logic [RES_W-1:0] NEG_FULLSCALE_14 = 16'h2000;
  localparam logic [RES_W-1:0] POS_FULLSCALE_14 = 16'h1fff;
  localparam logic [RES_W-1:0] MID_SCALE_CODE = 16'h0000;
  // Averaging-enable field encodings
  localparam logic [1:0] AVG_TWO = 2'h2;
  localparam logic [1:0] AVG_FOUR = 2'h3;
  localparam logic [1:0] AVG_DEFAULT = 2'h0;
  // Read/config protocol selector reset value (mode 0, single data rate)
  localparam logic [2:0] PROTO_DEFAULT = 3'h0;
  // Timing, clock 50 MHz
  localparam int CLK_MHZ = 50;
  localparam int CONV_TIME_NS = 300;
  localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int RST_LOW_MAX_NS = 1000;
  localparam int RST_LOW_MAX_CYC = (RST_LOW_MAX_NS * CLK_MHZ) / 1000;
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] RST_LIMIT = CNT_W'(RST_LOW_MAX_CYC);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam int ACC_W = RES_W + 2;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_WAKE = 2'b11,
    ST_HOLD_LOW = 2'b10
  } dacs_state_t;
endpackage

// ### verilog/dacs_seq.sv
// Conversion sequencer: state machine, coding, saturation and averaging
`timescale 1ns/10ps
module dacs_seq
  import dacs_pkg::*;
(
  input wire logic ref_clk, // Internal conversion clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic convert_start_in, // Host convert-start pin
  input wire logic powerdown_reset_in, // Shared power-down/reset pin, active low
  input wire logic cs_n, // Host chip select, active low
  input wire logic strobe_in, // Strobe from the read interface
  input wire logic narrow_mode, // High selects the 14-bit variant
  input wire logic [1:0] averaging_enable_field, // Averaging mode
  input wire logic cfg_write, // Pulse: load configuration inputs
  input wire logic half_ref_offset_enable, // Offset bit value to load
  input wire logic signed [RES_W+1:0] raw_a, // Channel A converter raw code
  input wire logic signed [RES_W+1:0] raw_b, // Channel B converter raw code
  output logic sampling_state, // Inputs connected to sampling caps
  output logic converting_state, // Both converters busy
  output logic conversion_done_internal, // One-cycle end of conversion
  output logic powered_down, // Power-down state
  output logic [RES_W-1:0] result_a, // Channel A result
  output logic [RES_W-1:0] result_b, // Channel B result
  output logic ready_strobe_out, // Shared ready/strobe pin
  output logic half_ref_offset_on, // Raises half-reference by 100 mV
  output logic [1:0] averaging_config, // Active averaging mode
  output logic [2:0] read_protocol, // Read protocol selector
  output logic [2:0] config_protocol // Configuration protocol selector
);
  typedef struct packed {
    dacs_state_t st;
    logic [2:0] cv_sync;
    logic [2:0] pd_sync;
    logic cv_q;
    logic pd_q;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] low_cnt;
    logic pdown;
    logic done;
    logic [1:0] avg;
    logic [1:0] nsamp;
    logic signed [ACC_W-1:0] acc_a;
    logic signed [ACC_W-1:0] acc_b;
    logic [RES_W-1:0] res_a;
    logic [RES_W-1:0] res_b;
    logic ready;
    logic offs;
  } dacs_regs_t;

  dacs_regs_t s_reg;
  dacs_regs_t s_next;

  // Clamp to the full-scale codes of the selected variant
  function automatic logic [RES_W-1:0] sat(input logic signed [ACC_W-1:0] v, input logic nar);
    logic signed [ACC_W-1:0] lo;
    logic signed [ACC_W-1:0] hi;
    lo = nar ? -(ACC_W'(1) <<< (RES_W_NARROW - 1)) : -(ACC_W'(1) <<< (RES_W - 1));
    hi = nar ? (ACC_W'(1) <<< (RES_W_NARROW - 1)) - ACC_W'(1) : (ACC_W'(1) <<< (RES_W - 1)) - ACC_W'(1);
    if (v < lo)
      sat = nar ? NEG_FULLSCALE_14 : NEG_FULLSCALE_16;
    else if (v > hi)
      sat = nar ? POS_FULLSCALE_14 : POS_FULLSCALE_16;
    else if (nar)
      sat = {2'b00, v[RES_W_NARROW-1:0]};
    else
      sat = v[RES_W-1:0];
  endfunction

  // Group size in samples minus one
  function automatic logic [1:0] grp_last(input logic [1:0] m);
    case (m)
      AVG_TWO: grp_last = 2'd1;
      AVG_FOUR: grp_last = 2'd3;
      default: grp_last = 2'd0;
    endcase
  endfunction

  logic cv_rise;
  logic pd_fall;
  logic pd_rise;
  logic pd_low;
  logic signed [ACC_W-1:0] sum_a;
  logic signed [ACC_W-1:0] sum_b;
  // Pin edges count once the second and third stages agree
  assign pd_low = (s_reg.pd_sync[1] == s_reg.pd_sync[2]) ? ~s_reg.pd_sync[2] : ~s_reg.pd_q;
  assign cv_rise = (s_reg.cv_sync[1] == s_reg.cv_sync[2]) && s_reg.cv_sync[2] && !s_reg.cv_q;
  assign pd_fall = pd_low && s_reg.pd_q;
  assign pd_rise = !pd_low && !s_reg.pd_q;
  assign sum_a = s_reg.acc_a + ACC_W'(raw_a);
  assign sum_b = s_reg.acc_b + ACC_W'(raw_b);

  always_comb begin
    s_next = s_reg;
    s_next.cv_sync = {s_reg.cv_sync[1:0], convert_start_in};
    s_next.pd_sync = {s_reg.pd_sync[1:0], powerdown_reset_in};
    if (s_reg.cv_sync[1] == s_reg.cv_sync[2])
      s_next.cv_q = s_reg.cv_sync[2];
    s_next.pd_q = !pd_low;
    s_next.done = 1'b0;
    if (cfg_write) begin
      s_next.offs = half_ref_offset_enable;
      s_next.avg = averaging_enable_field;
    end
    if (cv_rise)
      s_next.ready = 1'b0;
    case (s_reg.st)
      ST_SAMPLE: begin
        if (pd_fall) begin
          s_next.st = ST_HOLD_LOW;
          s_next.low_cnt = CNT_ZERO;
        end else if (cv_rise) begin
          s_next.st = ST_CONVERT;
          s_next.cnt = CNT_ZERO;
        end
      end
      ST_CONVERT: begin
        // Counted on the internal clock only
        s_next.cnt = s_reg.cnt + CNT_ONE;
        if (pd_fall) begin
          s_next.st = ST_HOLD_LOW;
          s_next.low_cnt = CNT_ZERO;
        end else if (s_reg.cnt == CONV_LAST) begin
          s_next.st = ST_SAMPLE;
          s_next.done = 1'b1;
          if (s_reg.nsamp == grp_last(s_reg.avg)) begin
            // Divide by group size with arithmetic shift
            case (s_reg.avg)
              AVG_TWO: begin
                s_next.res_a = sat(sum_a >>> 1, narrow_mode);
                s_next.res_b = sat(sum_b >>> 1, narrow_mode);
              end
              AVG_FOUR: begin
                s_next.res_a = sat(sum_a >>> 2, narrow_mode);
                s_next.res_b = sat(sum_b >>> 2, narrow_mode);
              end
              default: begin
                s_next.res_a = sat(ACC_W'(raw_a), narrow_mode);
                s_next.res_b = sat(ACC_W'(raw_b), narrow_mode);
              end
            endcase
            s_next.ready = 1'b1;
            s_next.nsamp = 2'd0;
            s_next.acc_a = '0;
            s_next.acc_b = '0;
          end else begin
            s_next.nsamp = s_reg.nsamp + 2'd1;
            s_next.acc_a = sum_a;
            s_next.acc_b = sum_b;
          end
        end
      end
      ST_HOLD_LOW: begin
        // Short low pulse is reset, long one is power-down
        if (s_reg.low_cnt != RST_LIMIT)
          s_next.low_cnt = s_reg.low_cnt + CNT_ONE;
        else
          s_next.pdown = 1'b1;
        // Configuration held at defaults on every cycle of the low pulse
        s_next.avg = AVG_DEFAULT;
        s_next.offs = 1'b0;
        s_next.nsamp = 2'd0;
        s_next.acc_a = '0;
        s_next.acc_b = '0;
        s_next.ready = 1'b0;
        if (pd_rise) begin
          s_next.st = ST_WAKE;
          s_next.cnt = CNT_ZERO;
        end
      end
      ST_WAKE: begin
        s_next.cnt = s_reg.cnt + CNT_ONE;
        if (pd_fall) begin
          s_next.st = ST_HOLD_LOW;
          s_next.low_cnt = CNT_ZERO;
        end else if (s_reg.cnt == WAKE_LAST) begin
          s_next.st = ST_SAMPLE;
          s_next.pdown = 1'b0;
        end
      end
      default: s_next.st = ST_SAMPLE;
    endcase
    // Mode change restarts the group; placed after the state case so it also
    // wins over a mid-group sample that lands in the same cycle
    if (cfg_write && averaging_enable_field != s_reg.avg) begin
      s_next.nsamp = 2'h0;
      s_next.acc_a = '0;
      s_next.acc_b = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.st <= ST_SAMPLE;
      s_reg.pd_sync <= 3'h7;
      s_reg.pd_q <= 1'b1;
      s_reg.avg <= AVG_DEFAULT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sampling_state = (s_reg.st == ST_SAMPLE);
  assign converting_state = (s_reg.st == ST_CONVERT);
  assign conversion_done_internal = s_reg.done;
  assign powered_down = s_reg.pdown;
  assign result_a = s_reg.res_a;
  assign result_b = s_reg.res_b;
  assign ready_strobe_out = cs_n ? s_reg.ready : strobe_in;
  assign half_ref_offset_on = s_reg.offs;
  assign averaging_config = s_reg.avg;
  assign read_protocol = PROTO_DEFAULT;
  assign config_protocol = PROTO_DEFAULT;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_start_converts: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_reg.st == ST_SAMPLE && cv_rise && !pd_fall) |=> converting_state)
    else $error("convert-start edge did not start conversion");
  a_fall_resets: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_reg.st == ST_SAMPLE && pd_fall) |=> s_reg.st == ST_HOLD_LOW)
    else $error("reset edge ignored in sampling state");
  a_done_samples: assert property (@(posedge ref_clk) disable iff (!nrst)
    conversion_done_internal |-> sampling_state && $past(converting_state))
    else $error("done without return to sampling");
  a_conv_length: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(converting_state) |-> (!sampling_state) [*8])
    else $error("conversion ended too early");
  a_ready_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(s_reg.ready) |-> $past(converting_state) && conversion_done_internal)
    else $error("ready rose without finished group");
  a_reset_defaults: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_reg.st == ST_HOLD_LOW) |=> averaging_config == AVG_DEFAULT && !half_ref_offset_on)
    else $error("configuration not restored in reset");
  a_pin_mux: assert property (@(posedge ref_clk) disable iff (!nrst)
    cs_n |-> ready_strobe_out == s_reg.ready)
    else $error("shared pin not showing ready");
  a_sat_range: assert property (@(posedge ref_clk) disable iff (!nrst)
    (narrow_mode && $changed(result_a)) |-> result_a[RES_W-1:RES_W_NARROW] == 2'b00)
    else $error("narrow result out of range");

  // ----------------------------------------
  // Timing and state checks
  // ----------------------------------------
  // A cut conversion leaves through reset and wake, which together outlast the conversion time
  a_conv_time: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(converting_state) |->
      ##15 (conversion_done_internal || s_reg.st == ST_HOLD_LOW || s_reg.st == ST_WAKE))
    else $error("conversion did not end on time");
  a_done_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
    conversion_done_internal |=> !conversion_done_internal)
    else $error("done held longer than one cycle");
  a_results_at_done: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($changed(result_a) || $changed(result_b)) |-> conversion_done_internal)
    else $error("result changed outside a conversion end");
  a_pdown_state: assert property (@(posedge ref_clk) disable iff (!nrst)
    powered_down |-> (s_reg.st == ST_HOLD_LOW || s_reg.st == ST_WAKE))
    else $error("powered down outside reset or wake");
  a_hold_until_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_reg.st == ST_HOLD_LOW && !pd_rise) |=> s_reg.st == ST_HOLD_LOW)
    else $error("left reset before the pin rose");
  a_wake_length: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_reg.st == ST_WAKE && s_reg.cnt != WAKE_LAST && !pd_fall) |=> s_reg.st == ST_WAKE)
    else $error("wake ended early");
  a_wake_ends: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(powered_down) |-> sampling_state)
    else $error("power-down exit not into sampling");
  a_mode_restart: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cfg_write && averaging_enable_field != averaging_config) |=> s_reg.nsamp == 2'h0 && s_reg.acc_a == '0)
    else $error("mode change kept a partial group");
  a_strobe_pass: assert property (@(posedge ref_clk) disable iff (!nrst)
    !cs_n |-> ready_strobe_out == strobe_in)
    else $error("shared pin not showing strobe");
  a_no_avg_ready: assert property (@(posedge ref_clk) disable iff (!nrst)
    (conversion_done_internal && $past(averaging_config) != AVG_TWO && $past(averaging_config) != AVG_FOUR)
      |-> s_reg.ready)
    else $error("plain mode result not ready");
  a_ready_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_reg.st == ST_SAMPLE && cv_rise) |=> !s_reg.ready)
    else $error("ready kept after a start edge");
  a_group_two: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($rose(s_reg.ready) && $past(averaging_config) == AVG_TWO) |-> $past(s_reg.nsamp) == 2'h1)
    else $error("two-sample group size wrong");
  a_group_four: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($rose(s_reg.ready) && $past(averaging_config) == AVG_FOUR) |-> $past(s_reg.nsamp) == 2'h3)
    else $error("four-sample group size wrong");
endmodule

// ### dv/dacs_host.sv
// Host model driving convert-start and the power-down/reset pin
`timescale 1ns/10ps
module dacs_host (
  input wire logic ref_clk, // Clock
  output logic convert_start_in, // Start pin
  output logic powerdown_reset_in // Reset pin, active low
);
  // Start edge spacing must cover conversion plus pin sync
  localparam int GAP = 20;
  int cyc = 0;
  int last = -100;
  initial begin
    convert_start_in = 1'b0;
    powerdown_reset_in = 1'b1;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end
  task automatic start_conv();
    @(posedge ref_clk);
    while (cyc - last < GAP) @(posedge ref_clk);
    convert_start_in <= 1'b1;
    last = cyc;
    repeat (4) @(posedge ref_clk);
    convert_start_in <= 1'b0;
  endtask
  task automatic pd_drive(input logic v);
    @(posedge ref_clk);
    powerdown_reset_in <= v;
  endtask
endmodule

// ### dv/dacs_seq_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module dacs_seq_test;
  import dacs_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_n = 1'b1;
  logic strobe_in = 1'b0;
  logic narrow_mode = 1'b0;
  logic [1:0] averaging_enable_field = 2'h0;
  logic cfg_write = 1'b0;
  logic half_ref_offset_enable = 1'b0;
  logic signed [RES_W+1:0] raw_a = 18'h00000;
  logic signed [RES_W+1:0] raw_b = 18'h00000;
  logic convert_start_in, powerdown_reset_in, sampling_state, converting_state;
  logic conversion_done_internal, powered_down, ready_strobe_out, half_ref_offset_on;
  logic [RES_W-1:0] result_a, result_b;
  logic [1:0] averaging_config;
  logic [2:0] read_protocol, config_protocol;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  logic [17:0] tr [6] = '{18'h00123, 18'h3fffb, 18'h1ffff, 18'h20000, 18'h0ffff, 18'h30000};
  logic [15:0] te [6] = '{16'h0123, 16'hfffb, 16'h7fff, 16'h8000, 16'h1fff, 16'h2000};
  logic [17:0] qa [4] = '{18'h00001, 18'h00002, 18'h00003, 18'h00006};

  always #10 ref_clk = ~ref_clk;

  dacs_host host (.ref_clk(ref_clk), .convert_start_in(convert_start_in), .powerdown_reset_in(powerdown_reset_in));

  dacs_seq DUT (.ref_clk(ref_clk), .nrst(nrst), .convert_start_in(convert_start_in),
    .powerdown_reset_in(powerdown_reset_in), .cs_n(cs_n), .strobe_in(strobe_in), .narrow_mode(narrow_mode),
    .averaging_enable_field(averaging_enable_field), .cfg_write(cfg_write),
    .half_ref_offset_enable(half_ref_offset_enable), .raw_a(raw_a), .raw_b(raw_b),
    .sampling_state(sampling_state), .converting_state(converting_state),
    .conversion_done_internal(conversion_done_internal), .powered_down(powered_down),
    .result_a(result_a), .result_b(result_b), .ready_strobe_out(ready_strobe_out),
    .half_ref_offset_on(half_ref_offset_on), .averaging_config(averaging_config),
    .read_protocol(read_protocol), .config_protocol(config_protocol));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cfg(input logic [1:0] mode, input logic off);
    @(posedge ref_clk);
    averaging_enable_field <= mode;
    half_ref_offset_enable <= off;
    cfg_write <= 1'b1;
    @(posedge ref_clk);
    cfg_write <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Done is a one-cycle pulse, so poll every cycle just after the edge
  task automatic conv(input logic [17:0] a, input logic [17:0] b);
    int n;
    @(posedge ref_clk);
    raw_a <= a;
    raw_b <= b;
    host.start_conv();
    #1;
    check("busy", converting_state, 1'b1);
    check("sampling", sampling_state, 1'b0);
    n = 0;
    while (conversion_done_internal !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("done", conversion_done_internal, 1'b1);
    check("sampling", sampling_state, 1'b1);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("sampling", sampling_state, 1'b1);
    check("rd_proto", read_protocol, PROTO_DEFAULT);
    check("cf_proto", config_protocol, PROTO_DEFAULT);
    for (int i = 0; i < 6; i += 2) begin
      @(posedge ref_clk);
      narrow_mode <= (i == 4);
      conv(tr[i], tr[i+1]);
      check("result_a", result_a, te[i]);
      check("result_b", result_b, te[i+1]);
      check("ready", ready_strobe_out, 1'b1);
    end
    @(posedge ref_clk);
    narrow_mode <= 1'b0;
    cs_n <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      strobe_in <= s[0];
      #1;
      check("strobe", ready_strobe_out, s[0]);
    end
    @(posedge ref_clk);
    cs_n <= 1'b1;
    cfg(AVG_FOUR, 1'b1);
    check("avg_mode", averaging_config, AVG_FOUR);
    check("offset", half_ref_offset_on, 1'b1);
    conv(18'h00064, 18'h00064);
    // Mode change must drop the partial group
    cfg(AVG_TWO, 1'b1);
    check("avg_mode", averaging_config, AVG_TWO);
    conv(18'h0000a, 18'h3fffc);
    check("ready", ready_strobe_out, 1'b0);
    conv(18'h0000d, 18'h3fff9);
    check("ready", ready_strobe_out, 1'b1);
    check("result_a", result_a, 16'h000b);
    check("result_b", result_b, 16'hfffa);
    cfg(AVG_FOUR, 1'b1);
    for (int i = 0; i < 4; i++) begin
      conv(qa[i], (i == 3) ? 18'h3fffe : 18'h3ffff);
      check("ready", ready_strobe_out, i == 3);
    end
    check("result_a", result_a, 16'h0003);
    check("result_b", result_b, 16'hfffe);
    cfg(2'h1, 1'b1);
    conv(18'h00007, 18'h00007);
    check("result_a", result_a, 16'h0007);
    host.start_conv();
    host.pd_drive(1'b0);
    repeat (5) @(posedge ref_clk);
    #1;
    check("busy", converting_state, 1'b0);
    check("pdown", powered_down, 1'b0);
    host.pd_drive(1'b1);
    repeat (60) @(posedge ref_clk);
    #1;
    check("sampling", sampling_state, 1'b1);
    check("avg_mode", averaging_config, AVG_DEFAULT);
    check("offset", half_ref_offset_on, 1'b0);
    host.pd_drive(1'b0);
    repeat (5) @(posedge ref_clk);
    #1;
    check("sampling", sampling_state, 1'b0);
    repeat (60) @(posedge ref_clk);
    #1;
    check("pdown", powered_down, 1'b1);
    host.pd_drive(1'b1);
    repeat (60) @(posedge ref_clk);
    #1;
    check("pdown", powered_down, 1'b0);
    conv(18'h00005, 18'h00005);
    check("result_a", result_a, 16'h0005);
    stop_test();
  end
endmodule
